// *** core/sspfr_top.sv ***
`timescale 1ns/1ns
module sspfr_top #(
  parameter int NSLOTS = sspfr_pkg::NSLOTS,
  parameter int PME_DELAY_CYCLES = sspfr_pkg::PME_DELAY_CYCLES
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sspfr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins
  input wire logic main_power_valid,
  input wire logic test_in,
  input wire logic standby_input_good,
  input wire sspfr_pkg::sspfr_slot_in_t [NSLOTS-1:0] slot_in,
  output sspfr_pkg::sspfr_slot_out_t [NSLOTS-1:0] slot_out,
  output logic gated_wake_out_n,
  // Controller link
  input wire logic link_clk,
  input wire logic status_load_n,
  input wire logic status_chain_in,
  input wire logic control_chain_in,
  input wire logic control_latch,
  input wire logic status_chain_pin_in,
  output logic status_chain_out,
  output logic status_chain_out_oe,
  input wire logic control_chain_pin_in,
  output logic control_chain_out,
  output logic control_chain_out_oe
);

  localparam int SW = NSLOTS * sspfr_pkg::STS_BITS;
  localparam int CW = NSLOTS * sspfr_pkg::CTL_BITS;
  localparam int TW = $clog2(PME_DELAY_CYCLES + 1);
  localparam logic [TW-1:0] DELAY_LAST = TW'(PME_DELAY_CYCLES - 1);

  function automatic logic [1:0] cap_decode(input logic not_gnd,
                                            input logic open_pin);
    cap_decode = {open_pin, not_gnd | open_pin};
  endfunction : cap_decode

  function automatic sspfr_pkg::sspfr_mode_t mode_decode(
      input logic [1:0] strap, input logic tst);
    if (!tst && strap == sspfr_pkg::MODE_OPER_STRAP)
      mode_decode = sspfr_pkg::MODE_OPERATIONAL;
    else if (tst && strap == 2'h0)
      mode_decode = sspfr_pkg::MODE_NAND_TEST;
    else if (tst && strap == 2'h1)
      mode_decode = sspfr_pkg::MODE_TRISTATE_TEST;
    else
      mode_decode = sspfr_pkg::MODE_RESERVED;
  endfunction : mode_decode

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  sspfr_pkg::sspfr_slot_in_t [NSLOTS-1:0] slot_s1, slot_s2;
  logic main_power_valid_s1, main_power_valid_s2, main_power_valid_d;
  logic test_s1, test_s2, sbin_s1, sbin_s2;
  logic stpin_s1, stpin_s2, ctpin_s1, ctpin_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_s1 <= '0;
      slot_s2 <= '0;
      {main_power_valid_s1, main_power_valid_s2, main_power_valid_d} <= '0;
      {test_s1, test_s2, sbin_s1, sbin_s2} <= '0;
      {stpin_s1, stpin_s2, ctpin_s1, ctpin_s2} <= '0;
    end else begin
      slot_s1 <= slot_in;
      slot_s2 <= slot_s1;
      main_power_valid_s1 <= main_power_valid;
      main_power_valid_s2 <= main_power_valid_s1;
      main_power_valid_d <= main_power_valid_s2;
      test_s1 <= test_in;
      test_s2 <= test_s1;
      sbin_s1 <= standby_input_good;
      sbin_s2 <= sbin_s1;
      stpin_s1 <= status_chain_pin_in;
      stpin_s2 <= stpin_s1;
      ctpin_s1 <= control_chain_pin_in;
      ctpin_s2 <= ctpin_s1;
    end
  end

  wire main_power_valid_rise = main_power_valid_s2 & ~main_power_valid_d;

  ////////////////////////////////////////////////////////////////////////
  // Strap capture and chain drive enables
  logic [1:0] mode_reg;
  logic strap_test_reg;
  sspfr_pkg::sspfr_mode_t mode_now;
  assign mode_now = mode_decode(mode_reg, strap_test_reg);
  wire oper = (mode_now == sspfr_pkg::MODE_OPERATIONAL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= '0;
      strap_test_reg <= 1'b0;
    end else if (main_power_valid_rise) begin
      mode_reg <= {ctpin_s2, stpin_s2};
      strap_test_reg <= test_s2;
    end
  end

  // Pins stay released through the strap edge so the pull-ups are read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_chain_out_oe <= 1'b0;
      control_chain_out_oe <= 1'b0;
    end else begin
      status_chain_out_oe <= main_power_valid_s2 & main_power_valid_d & oper;
      control_chain_out_oe <= main_power_valid_s2 & main_power_valid_d & oper;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [31:0] ctrl_reg;
  logic [SW-1:0] status_word_reg;
  logic [CW-1:0] ctl_s1, ctl_s2;
  logic [NSLOTS-1:0] aux_fault_reg, standby_on_reg, conn_reg;
  logic [TW-1:0] cnt_reg [NSLOTS];

  logic [31:0] status_rd;
  always_comb begin
    status_rd = '0;
    for (int i = 0; i < NSLOTS; i++) begin
      status_rd[i*sspfr_pkg::ST_SLOT_W + sspfr_pkg::ST_AUX_FAULT] =
        aux_fault_reg[i];
      status_rd[i*sspfr_pkg::ST_SLOT_W + sspfr_pkg::ST_WAKE_CONN] =
        conn_reg[i];
      status_rd[i*sspfr_pkg::ST_SLOT_W + sspfr_pkg::ST_STANDBY_ON] =
        standby_on_reg[i];
      status_rd[i*sspfr_pkg::ST_SLOT_W + sspfr_pkg::ST_MAIN_FAULT] =
        slot_s2[i].main_fault;
    end
    status_rd[sspfr_pkg::ST_MODE_LSB +: 2] = mode_reg;
    status_rd[sspfr_pkg::ST_OPERATIONAL] = oper;
  end

  wire setup = psel & ~penable;
  wire wr_ctrl = psel & penable & pready & pwrite &
                 (paddr == sspfr_pkg::ADDR_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup & (paddr != sspfr_pkg::ADDR_CTRL) &
                 (paddr != sspfr_pkg::ADDR_STATUS);
      if (setup && !pwrite && paddr == sspfr_pkg::ADDR_CTRL)
        prdata <= ctrl_reg;
      else if (setup && !pwrite && paddr == sspfr_pkg::ADDR_STATUS)
        prdata <= status_rd;
      else if (setup)
        prdata <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_reg <= sspfr_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= pwdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot standby, wake gating and fault latch
  logic [NSLOTS-1:0] sw_closed, supply_ok;
  always_comb begin
    for (int i = 0; i < NSLOTS; i++) begin
      sw_closed[i] = ~slot_s2[i].sw_open & ~slot_s2[i].sw_at_5v;
      supply_ok[i] = sw_closed[i] & sbin_s2 & ~aux_fault_reg[i] &
                     ~slot_s2[i].standby_short & ctrl_reg[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_fault_reg <= '0;
      standby_on_reg <= '0;
    end else begin
      for (int i = 0; i < NSLOTS; i++) begin
        // Set beats clear if a short coincides with the switch opening
        if (slot_s2[i].standby_short && standby_on_reg[i])
          aux_fault_reg[i] <= 1'b1;
        else if (!sw_closed[i] || !sbin_s2)
          aux_fault_reg[i] <= 1'b0;
        standby_on_reg[i] <= supply_ok[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_reg <= '0;
      for (int i = 0; i < NSLOTS; i++)
        cnt_reg[i] <= '0;
    end else begin
      for (int i = 0; i < NSLOTS; i++) begin
        // Timer restarts from zero on any dropout of standby
        if (!(supply_ok[i] && standby_on_reg[i] &&
              slot_s2[i].standby_good)) begin
          cnt_reg[i] <= '0;
          conn_reg[i] <= 1'b0;
        end else if (cnt_reg[i] == DELAY_LAST) begin
          conn_reg[i] <= 1'b1;
        end else begin
          cnt_reg[i] <= cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_out <= '0;
      gated_wake_out_n <= 1'b1;
    end else begin
      gated_wake_out_n <= 1'b1;
      for (int i = 0; i < NSLOTS; i++) begin
        slot_out[i].slot_standby_supply <= supply_ok[i];
        slot_out[i].wake_connected <= conn_reg[i] & supply_ok[i];
        if (conn_reg[i] && supply_ok[i] && !slot_s2[i].wake_n)
          gated_wake_out_n <= 1'b0;
        {slot_out[i].capability_bit_high, slot_out[i].capability_bit_low}
          <= cap_decode(slot_s2[i].cap_not_ground, slot_s2[i].cap_open);
        slot_out[i].main_enable <= slot_s2[i].sw_at_5v |
          (main_power_valid_s2 & oper & ctl_s2[i*sspfr_pkg::CTL_BITS +
                                    sspfr_pkg::CB_MAIN_EN]);
        if (slot_s2[i].sw_at_5v)
          slot_out[i].attention_indicator <= slot_s2[i].main_fault;
        else if (!main_power_valid_s2)
          slot_out[i].attention_indicator <= aux_fault_reg[i];
        else if (test_s2)
          slot_out[i].attention_indicator <=
            slot_s2[i].main_fault | aux_fault_reg[i];
        else if (slot_s2[i].sw_open)
          slot_out[i].attention_indicator <= slot_s2[i].main_fault;
        else
          slot_out[i].attention_indicator <= oper &
            ctl_s2[i*sspfr_pkg::CTL_BITS + sspfr_pkg::CB_ATTN];
      end
    end
  end

  // Status word handed to the link domain; bits change slowly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word_reg <= '0;
    end else begin
      for (int i = 0; i < NSLOTS; i++) begin
        status_word_reg[i*sspfr_pkg::STS_BITS +: sspfr_pkg::STS_BITS] <=
          '0;
        status_word_reg[i*sspfr_pkg::STS_BITS + sspfr_pkg::SB_SW_OPEN] <=
          ~sw_closed[i];
        status_word_reg[i*sspfr_pkg::STS_BITS + sspfr_pkg::SB_COMB_FAULT]
          <= slot_s2[i].main_fault | aux_fault_reg[i];
        status_word_reg[i*sspfr_pkg::STS_BITS + sspfr_pkg::SB_AUX_FAULT]
          <= aux_fault_reg[i];
        {status_word_reg[i*sspfr_pkg::STS_BITS + sspfr_pkg::SB_CAP_HIGH],
         status_word_reg[i*sspfr_pkg::STS_BITS + sspfr_pkg::SB_CAP_LOW]}
          <= cap_decode(slot_s2[i].cap_not_ground, slot_s2[i].cap_open);
      end
    end
  end

  // Latched control bits are levels; a two-flop pass per bit suffices
  logic [CW-1:0] ctl_lat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_s1 <= '0;
      ctl_s2 <= '0;
    end else begin
      ctl_s1 <= ctl_lat;
      ctl_s2 <= ctl_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain: status and control chains
  logic main_power_valid_l1, main_power_valid_l2;
  logic [SW-1:0] stword_l1, stword_l2, stat_sh;
  logic [CW-1:0] ctrl_sh;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      {main_power_valid_l1, main_power_valid_l2} <= '0;
      stword_l1 <= '0;
      stword_l2 <= '0;
    end else begin
      main_power_valid_l1 <= main_power_valid_s2;
      main_power_valid_l2 <= main_power_valid_l1;
      stword_l1 <= status_word_reg;
      stword_l2 <= stword_l1;
    end
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn)
      stat_sh <= '0;
    else if (!main_power_valid_l2)
      stat_sh <= '0;
    else if (!status_load_n)
      stat_sh <= stword_l2;
    else
      stat_sh <= {status_chain_in, stat_sh[SW-1:1]};
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sh <= '0;
      ctl_lat <= '0;
    end else if (!main_power_valid_l2) begin
      ctrl_sh <= '0;
      ctl_lat <= '0;
    end else begin
      ctrl_sh <= {control_chain_in, ctrl_sh[CW-1:1]};
      if (control_latch)
        ctl_lat <= ctrl_sh;
    end
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      status_chain_out <= 1'b1;
      control_chain_out <= 1'b1;
    end else begin
      status_chain_out <= stat_sh[0];
      control_chain_out <= ctrl_sh[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  for (genvar g = 0; g < NSLOTS; g++) begin : gchk
    chk_open_cuts_standby: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sw_closed[g] |=> !standby_on_reg[g] &&
        !slot_out[g].slot_standby_supply)
      else $error("standby stayed on with switch open");
    chk_close_restores: assert property (
      @(posedge pclk) disable iff (!presetn)
      supply_ok[g] |=> slot_out[g].slot_standby_supply)
      else $error("standby not restored");
    chk_wake_after_delay: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(conn_reg[g]) |-> $past(cnt_reg[g]) == DELAY_LAST &&
        $past(standby_on_reg[g]) && $past(slot_s2[g].standby_good))
      else $error("wake joined before delay");
    chk_fault_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      aux_fault_reg[g] && sw_closed[g] && sbin_s2 |=> aux_fault_reg[g])
      else $error("standby fault released early");
    chk_fault_cuts_all: assert property (
      @(posedge pclk) disable iff (!presetn)
      slot_s2[g].standby_short |=> !slot_out[g].slot_standby_supply &&
        !slot_out[g].wake_connected)
      else $error("fault did not cut standby and wake");
    chk_open_cuts_wake: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sw_closed[g] |=> !conn_reg[g] && !slot_out[g].wake_connected)
      else $error("wake stayed on after open");
    chk_attn_unpowered: assert property (
      @(posedge pclk) disable iff (!presetn)
      !main_power_valid_s2 && !slot_s2[g].sw_at_5v |=>
        slot_out[g].attention_indicator == $past(aux_fault_reg[g]))
      else $error("indicator not standby fault");
    chk_attn_test: assert property (
      @(posedge pclk) disable iff (!presetn)
      main_power_valid_s2 && test_s2 && !slot_s2[g].sw_at_5v |=>
        slot_out[g].attention_indicator ==
        ($past(slot_s2[g].main_fault) | $past(aux_fault_reg[g])))
      else $error("indicator not combined fault");
    chk_attn_5v: assert property (
      @(posedge pclk) disable iff (!presetn)
      slot_s2[g].sw_at_5v |=> slot_out[g].main_enable &&
        slot_out[g].attention_indicator == $past(slot_s2[g].main_fault))
      else $error("forced slot not enabled");
    chk_cap_open: assert property (
      @(posedge pclk) disable iff (!presetn)
      slot_s2[g].cap_open |=> slot_out[g].capability_bit_high &&
        slot_out[g].capability_bit_low)
      else $error("capability decode wrong");
    cov_wake_joined: cover property (
      @(posedge pclk) disable iff (!presetn) $rose(slot_out[g].wake_connected));
    cov_fault_latched: cover property (
      @(posedge pclk) disable iff (!presetn) $rose(aux_fault_reg[g]));
  end

  chk_strap_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    main_power_valid_rise |=> mode_reg == $past({ctpin_s2, stpin_s2}))
    else $error("straps not captured");
  chk_chain_released: assert property (
    @(posedge pclk) disable iff (!presetn)
    !main_power_valid_s2 |=> !status_chain_out_oe && !control_chain_out_oe)
    else $error("chain driven while unpowered");
  chk_oper_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    status_chain_out_oe |-> mode_reg == sspfr_pkg::MODE_OPER_STRAP &&
      !strap_test_reg)
    else $error("chain driven outside operational mode");
  cov_operational: cover property (
    @(posedge pclk) disable iff (!presetn) $rose(status_chain_out_oe));

endmodule : sspfr_top

// *** core/sspfr_pkg.sv ***
package sspfr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Sizes and defaults
  localparam int NSLOTS = 2;
  localparam int PME_DELAY_CYCLES = 1024;
  localparam int STS_BITS = 8;
  localparam int CTL_BITS = 2;

  ////////////////////////////////////////////////////////////////////////
  // APB register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  // Status register: one byte per slot, strap info above
  localparam int ST_SLOT_W = 8;
  localparam int ST_AUX_FAULT = 0;
  localparam int ST_WAKE_CONN = 1;
  localparam int ST_STANDBY_ON = 2;
  localparam int ST_MAIN_FAULT = 3;
  localparam int ST_MODE_LSB = 16;
  localparam int ST_OPERATIONAL = 20;

  ////////////////////////////////////////////////////////////////////////
  // Status chain byte per slot
  localparam int SB_SW_OPEN = 0;
  localparam int SB_COMB_FAULT = 2;
  localparam int SB_AUX_FAULT = 3;
  localparam int SB_CAP_LOW = 4;
  localparam int SB_CAP_HIGH = 5;

  // Control chain bits per slot
  localparam int CB_MAIN_EN = 0;
  localparam int CB_ATTN = 1;

  // Strap word {strap_select_1, strap_select_0}
  localparam logic [1:0] MODE_OPER_STRAP = 2'h3;

  typedef enum logic [1:0] {
    MODE_OPERATIONAL,
    MODE_NAND_TEST,
    MODE_TRISTATE_TEST,
    MODE_RESERVED
  } sspfr_mode_t;

  ////////////////////////////////////////////////////////////////////////
  // Per-slot pin groups
  typedef struct packed {
    logic sw_open;        // Switch above logic supply level
    logic sw_at_5v;       // Switch pulled to 5-V level
    logic standby_good;   // Slot standby above threshold
    logic standby_short;  // Slot standby short detected
    logic main_fault;     // Main power fault, active high
    logic wake_n;         // Slot wake request, active low
    logic cap_not_ground; // Capability comparator, low threshold
    logic cap_open;       // Capability comparator, high threshold
  } sspfr_slot_in_t;

  typedef struct packed {
    logic slot_standby_supply;
    logic wake_connected;
    logic attention_indicator;
    logic main_enable;
    logic capability_bit_high;
    logic capability_bit_low;
  } sspfr_slot_out_t;

endpackage : sspfr_pkg

// *** bench/sspfr_hp_ctl.sv ***
`timescale 1ns/1ns
module sspfr_hp_ctl (
  // Controller side of the link
  output logic link_clk,
  output logic status_load_n,
  output logic status_chain_in,
  output logic control_chain_in,
  output logic control_latch,
  // Device chain pins
  input wire logic sc_out,
  input wire logic sc_oe,
  input wire logic cc_out,
  input wire logic cc_oe,
  input wire logic [1:0] strap,
  output logic sc_pad,
  output logic cc_pad
);
  // Strap resistors win only while the device lets go
  assign sc_pad = sc_oe ? sc_out : strap[0];
  assign cc_pad = cc_oe ? cc_out : strap[1];
  initial begin
    link_clk = 1'b0;
    status_load_n = 1'b1;
    status_chain_in = 1'b0;
    control_chain_in = 1'b0;
    control_latch = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Clock runs only inside frames
  task automatic tick();
    #62 link_clk = 1'b1;
    #63 link_clk = 1'b0;
  endtask : tick
  // Idle edges first, so the synced copies are fresh
  task automatic read_status(output logic [16:0] w);
    repeat (3) tick();
    status_load_n = 1'b0;
    status_chain_in = 1'b1;
    tick();
    status_load_n = 1'b1;
    for (int i = 0; i < 17; i++) begin
      tick();
      w[i] = sc_out;
    end
    status_chain_in = 1'b0;
  endtask : read_status
  // Highest bit first, latch pulse closes the frame
  task automatic send_control(input logic [3:0] c);
    repeat (3) tick();
    for (int i = 3; i >= 0; i--) begin
      control_chain_in = c[i];
      tick();
    end
    control_latch = 1'b1;
    tick();
    control_latch = 1'b0;
    tick();
  endtask : send_control
endmodule : sspfr_hp_ctl

// *** bench/test_slot_standby_power_and_fault_report.sv ***
`timescale 1ns/1ns
module test_slot_standby_power_and_fault_report;
  localparam int PD = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic mpv, test_in, sig, gwo_n, err;
  sspfr_pkg::sspfr_slot_in_t [1:0] si;
  sspfr_pkg::sspfr_slot_out_t [1:0] so;
  logic lclk, sl_n, sci, cci, cl, sc_pad, cc_pad, sco, scoe, cco, ccoe;
  logic [1:0] strap;
  logic [16:0] w;
  int num_errors = 0;
  int total_checks = 0;
  int n;
  sspfr_top #(.NSLOTS(2), .PME_DELAY_CYCLES(PD)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_power_valid(mpv),
    .test_in(test_in), .standby_input_good(sig), .slot_in(si),
    .slot_out(so), .gated_wake_out_n(gwo_n), .link_clk(lclk),
    .status_load_n(sl_n), .status_chain_in(sci),
    .control_chain_in(cci), .control_latch(cl),
    .status_chain_pin_in(sc_pad), .status_chain_out(sco),
    .status_chain_out_oe(scoe), .control_chain_pin_in(cc_pad),
    .control_chain_out(cco), .control_chain_out_oe(ccoe));
  sspfr_hp_ctl hc (
    .link_clk(lclk), .status_load_n(sl_n), .status_chain_in(sci),
    .control_chain_in(cci), .control_latch(cl), .sc_out(sco),
    .sc_oe(scoe), .cc_out(cco), .cc_oe(ccoe), .strap(strap),
    .sc_pad(sc_pad), .cc_pad(cc_pad));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  // Slave latency is not assumed; the wait is bounded
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      num_errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, mpv, test_in} = '0;
    paddr = '0;
    pwdata = '0;
    sig = 1'b1;
    strap = 2'b11;
    si = '0;
    si[0].sw_open = 1'b1;
    si[0].wake_n = 1'b1;
    si[0].cap_not_ground = 1'b1;
    si[0].cap_open = 1'b1;
    si[1].sw_open = 1'b1;
    si[1].main_fault = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk(32'(so), 32'h0000_0000);
    chk({gwo_n, scoe, ccoe}, 3'b100);
    apb(1'b0, sspfr_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(rd, sspfr_pkg::CTRL_RESET);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(err, 1'b1);
    si[0].sw_open <= 1'b0;
    cyc(6);
    chk(so[0].slot_standby_supply, 1'b1);
    si[0].standby_good <= 1'b1;
    si[0].wake_n <= 1'b0;
    si[1].wake_n <= 1'b0;
    cyc(4);
    chk({so[0].wake_connected, gwo_n}, 2'b01);
    n = 4;
    do begin
      cyc(1);
      n++;
    end while (so[0].wake_connected !== 1'b1 && n < 40);
    chk(32'(n >= PD && n <= PD + 8), 32'h0000_0001);
    cyc(4);
    chk(gwo_n, 1'b0);
    si[0].standby_short <= 1'b1;
    cyc(5);
    chk({so[0].slot_standby_supply, so[0].wake_connected, gwo_n},
        3'b001);
    si[0].standby_short <= 1'b0;
    cyc(6);
    chk(so[0].slot_standby_supply, 1'b0);
    chk(so[0].attention_indicator, 1'b1);
    apb(1'b0, sspfr_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd[0], 1'b1);
    si[0].sw_open <= 1'b1;
    cyc(6);
    si[0].sw_open <= 1'b0;
    cyc(6);
    chk({so[0].slot_standby_supply, so[0].attention_indicator},
        2'b10);
    si[0].standby_short <= 1'b1;
    cyc(6);
    si[0].standby_short <= 1'b0;
    sig <= 1'b0;
    cyc(6);
    sig <= 1'b1;
    cyc(6);
    chk(so[0].slot_standby_supply, 1'b1);
    apb(1'b1, sspfr_pkg::ADDR_CTRL, 32'h0000_0002);
    cyc(6);
    chk(so[0].slot_standby_supply, 1'b0);
    apb(1'b1, sspfr_pkg::ADDR_CTRL, 32'h0000_0003);
    // Power up with operational straps
    mpv <= 1'b1;
    cyc(8);
    chk({scoe, ccoe}, 2'b11);
    apb(1'b0, sspfr_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd[20:16], 5'h13);
    hc.read_status(w);
    chk(w, 17'h1_0530);
    hc.send_control(4'b0110);
    chk(cco, 1'b1);
    cyc(8);
    chk({so[0].attention_indicator, so[0].main_enable}, 2'b10);
    chk({so[1].main_enable, so[1].attention_indicator}, 2'b11);
    si[1].main_fault <= 1'b0;
    cyc(6);
    chk(so[1].attention_indicator, 1'b0);
    test_in <= 1'b1;
    cyc(6);
    chk(so[0].attention_indicator, 1'b0);
    test_in <= 1'b0;
    si[0].sw_open <= 1'b1;
    si[0].sw_at_5v <= 1'b1;
    si[0].main_fault <= 1'b1;
    cyc(6);
    chk({so[0].main_enable, so[0].attention_indicator,
         so[0].slot_standby_supply}, 3'b110);
    si[0].main_fault <= 1'b0;
    cyc(6);
    chk(so[0].attention_indicator, 1'b0);
    for (int i = 0; i < 3; i++) begin
      si[1].cap_not_ground <= (i > 0);
      si[1].cap_open <= (i > 1);
      cyc(6);
      chk({so[1].capability_bit_high, so[1].capability_bit_low},
          {i > 1, i > 0});
    end
    // Second power up with a non-operational strap
    mpv <= 1'b0;
    strap <= 2'b01;
    cyc(8);
    mpv <= 1'b1;
    cyc(8);
    apb(1'b0, sspfr_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd[20:16], 5'h01);
    chk({scoe, ccoe}, 2'b00);
    summarize();
  end
endmodule : test_slot_standby_power_and_fault_report
